// ==== hdl/bsic_capture.sv ====
// synchronous input capture and burst counter front end of a burst sram
`timescale 1ns/100ps
`include "bsic_consts.svh"
// Summary of operation
// R1 - address captured only on a strobe with all three enables active
// R2 - capture loads the two lowest address bits into the burst counter
// R3 - byte write enable is active low; needed for per-lane writes
// R4 - counter steps on each edge with burst advance low during a burst
// R5 - every synchronous input is registered on the rising clock edge
// R6 - first chip enable is active low, selects device for new access
// R7 - second chip enable is active high, needed together with the others
// R8 - third chip enable is active low, needed together with the others
// R9 - both strobes together with first enable low: only the processor strobe is acted on
// R10 - global write low writes every lane regardless of lane controls
// R11 - chip enables only looked at when a new address is loaded
// R12 - output enable masked in first read cycle after deselect
// R13 - a strobe with any enable inactive deselects and starts nothing, except a processor strobe with first enable high, which is ignored
module bsic_capture
  import bsic_pkg::*;
(
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  input  wire logic [`BSIC_ADDR_W-1:0] i_addr,
  input  wire logic                    i_processor_addr_strobe_n,
  input  wire logic                    i_controller_addr_strobe_n,
  input  wire logic                    i_burst_advance_n,
  input  wire logic                    i_chip_enable_primary_n,
  input  wire logic                    i_chip_enable_high_side,
  input  wire logic                    i_chip_enable_third_n,
  input  wire logic                    i_byte_write_enable_n,
  input  wire logic [`BSIC_LANES-1:0]  i_byte_lane_select_n,
  input  wire logic                    i_global_write_n,
  input  wire logic                    i_output_enable_n,
  output logic      [`BSIC_ADDR_W-1:0] o_addr,
  output logic      [1:0]              o_burst_start_bits,
  output logic                         o_access_active,
  output logic                         o_write,
  output logic      [`BSIC_LANES-1:0]  o_write_lanes,
  output logic                         o_deselect,
  output logic                         o_data_oe
);
  bsic_core_t s_reg;
  bsic_core_t s_next;

  logic                   proc_go;
  logic                   ctrl_go;
  logic                   strobe;
  logic                   selected;
  logic                   cnt_load;
  logic                   cnt_adv;
  logic [`BSIC_LANES-1:0] req_lanes;

  // all three enables at their active levels
  function automatic logic chip_selected(input logic ce1_n, input logic ce2,
                                         input logic ce3_n);
    chip_selected = ~ce1_n & ce2 & ~ce3_n;  // see R6 see R7 see R8
  endfunction : chip_selected

  // lanes written this edge from global write, byte enable and lane selects
  function automatic logic [`BSIC_LANES-1:0] lanes_of(input logic gw_n,
      input logic bwe_n, input logic [`BSIC_LANES-1:0] bw_n);
    if (!gw_n) begin
      lanes_of = `BSIC_LANES_ALL;           // see R10
    end else if (!bwe_n) begin
      lanes_of = ~bw_n;                     // see R3
    end else begin
      lanes_of = `BSIC_LANES_NONE;
    end
  endfunction : lanes_of

  // strobe decode; processor strobe is ignored while the first enable is high
  assign proc_go   = ~i_processor_addr_strobe_n & ~i_chip_enable_primary_n;
  assign ctrl_go   = ~i_controller_addr_strobe_n;
  assign strobe    = proc_go | ctrl_go;
  assign selected  = chip_selected(i_chip_enable_primary_n, i_chip_enable_high_side,
                                   i_chip_enable_third_n);
  assign req_lanes = lanes_of(i_global_write_n, i_byte_write_enable_n,
                              i_byte_lane_select_n);
  assign cnt_load  = strobe & selected;                          // see R1
  assign cnt_adv   = ~strobe & (s_reg.state != BSIC_ST_DESEL)
                   & ~i_burst_advance_n;                         // see R4

  // next state of the capture stage
  always_comb begin
    s_next       = s_reg;
    s_next.lanes = `BSIC_LANES_NONE;
    if (strobe) begin
      if (selected) begin
        s_next.addr = i_addr;                                    // see R1
        // processor strobe wins and always opens as a read; write data follows
        if (proc_go || req_lanes == `BSIC_LANES_NONE) begin      // see R9
          s_next.state = BSIC_ST_READ;
        end else begin
          s_next.state = BSIC_ST_WRITE;
          s_next.lanes = req_lanes;
        end
      end else begin
        s_next.state = BSIC_ST_DESEL;                            // see R13
      end
    end else if (s_reg.state != BSIC_ST_DESEL) begin
      // burst continuation: enables are not consulted here
      if (req_lanes != `BSIC_LANES_NONE) begin                   // see R11
        s_next.state = BSIC_ST_WRITE;
        s_next.lanes = req_lanes;
      end else begin
        s_next.state = BSIC_ST_READ;
      end
    end
    s_next.first_read = (s_reg.state == BSIC_ST_DESEL)
                      && (s_next.state == BSIC_ST_READ);
    // output enable is only honoured once a read started from deselect has had a clock
    s_next.data_oe = (s_next.state == BSIC_ST_READ) && !i_output_enable_n
                   && !s_next.first_read;                        // see R12
    // own flop so the access flag leaves the block with no decode behind it
    s_next.active  = s_next.state != BSIC_ST_DESEL;
  end

  // single clock register of all capture state except the burst position
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s_reg.state      <= BSIC_ST_DESEL;
      s_reg.addr       <= `BSIC_ADDR_RST;
      s_reg.lanes      <= `BSIC_LANES_NONE;
      s_reg.first_read <= 1'b0;
      s_reg.data_oe    <= 1'b0;
      s_reg.active     <= 1'b0;
    end else begin
      s_reg <= s_next;                                           // see R5
    end
  end

  bsic_burst_counter u_counter (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_load    (cnt_load),
    .i_start   (i_addr[`BSIC_START_MSB:`BSIC_START_LSB]),
    .i_advance (cnt_adv),
    .o_pos     (o_burst_start_bits)
  );

  // outputs come from the flops; o_write and o_deselect are decoded from the state
  assign o_addr          = s_reg.addr;
  assign o_access_active = s_reg.active;
  assign o_write         = s_reg.state == BSIC_ST_WRITE;
  assign o_write_lanes   = s_reg.lanes;
  assign o_deselect      = s_reg.state == BSIC_ST_DESEL;
  assign o_data_oe       = s_reg.data_oe;

  // checks on the capture behaviour
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  property p_capture;
    strobe && selected |=> o_addr == $past(i_addr) && o_access_active;
  endproperty
  a_capture: assert property (p_capture) else $error("address not captured"); // see R1

  property p_start_bits;
    strobe && selected |=> o_burst_start_bits == $past(i_addr[1:0]);
  endproperty
  a_start_bits: assert property (p_start_bits) else $error("start bits wrong"); // see R2

  property p_no_bwe;
    !strobe && o_access_active && i_global_write_n && i_byte_write_enable_n
      |=> o_write_lanes == `BSIC_LANES_NONE && !o_write;
  endproperty
  a_no_bwe: assert property (p_no_bwe) else $error("write without enable"); // see R3

  property p_advance;
    !strobe && o_access_active && !i_burst_advance_n
      |=> o_burst_start_bits == 2'($past(o_burst_start_bits) + 2'h1);
  endproperty
  a_advance: assert property (p_advance) else $error("counter not advanced"); // see R4

  property p_hold;
    !strobe ##0 i_burst_advance_n |=> $stable(o_burst_start_bits) && $stable(o_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved without cause"); // see R5

  property p_ce1;
    ctrl_go && i_chip_enable_primary_n |=> o_deselect && !o_data_oe;
  endproperty
  a_ce1: assert property (p_ce1) else $error("first enable ignored"); // see R6

  property p_ce2;
    strobe && !i_chip_enable_high_side |=> o_deselect;
  endproperty
  a_ce2: assert property (p_ce2) else $error("second enable ignored"); // see R7

  property p_ce3;
    strobe && i_chip_enable_third_n
      |=> o_deselect && !o_data_oe && o_write_lanes == `BSIC_LANES_NONE;
  endproperty
  a_ce3: assert property (p_ce3) else $error("third enable ignored"); // see R8

  property p_proc_wins;
    proc_go && ctrl_go && selected |=> !o_write && o_write_lanes == `BSIC_LANES_NONE;
  endproperty
  a_proc_wins: assert property (p_proc_wins) else $error("controller strobe acted"); // see R9

  property p_global;
    !strobe && o_access_active && !i_global_write_n |=> o_write_lanes == `BSIC_LANES_ALL;
  endproperty
  a_global: assert property (p_global) else $error("global write partial"); // see R10

  property p_burst_enables;
    !strobe && o_access_active && !selected |=> o_access_active;
  endproperty
  a_burst_enables: assert property (p_burst_enables) else $error("burst broken"); // see R11

  property p_oe_mask;
    o_deselect && strobe && selected && proc_go |=> !o_data_oe;
  endproperty
  a_oe_mask: assert property (p_oe_mask) else $error("output enable not masked"); // see R12

  property p_desel;
    strobe && !selected |=> o_deselect && !o_write ##1 !o_write || $past(ctrl_go);
  endproperty
  a_desel: assert property (p_desel) else $error("deselect started access"); // see R13

  c_read_burst: cover property (cnt_load && proc_go ##1 cnt_adv [*3]);
  c_ctrl_write: cover property (cnt_load && ctrl_go && !i_byte_write_enable_n);
  c_desel_read: cover property (o_deselect ##1 o_access_active ##1 o_data_oe);
endmodule : bsic_capture

// ==== shared/bsic_consts.svh ====
// constants for the burst sram input capture block
`ifndef BSIC_CONSTS_SVH
`define BSIC_CONSTS_SVH
`define BSIC_ADDR_W      19
`define BSIC_LANES       4
`define BSIC_START_LSB   0
`define BSIC_START_MSB   1
`define BSIC_ADDR_RST    19'h00000
`define BSIC_POS_RST     2'h0
`define BSIC_LANES_NONE  4'h0
`define BSIC_LANES_ALL   4'hf
`endif

// ==== shared/bsic_pkg.sv ====
// types for the burst sram input capture block
`include "bsic_consts.svh"
package bsic_pkg;
  typedef enum logic [2:0] {
    BSIC_ST_DESEL = 3'b001,
    BSIC_ST_READ  = 3'b010,
    BSIC_ST_WRITE = 3'b100
  } bsic_state_t;

  typedef struct packed {
    bsic_state_t                 state;
    logic [`BSIC_ADDR_W-1:0]     addr;
    logic [`BSIC_LANES-1:0]      lanes;
    logic                        first_read;
    logic                        data_oe;
    logic                        active;
  } bsic_core_t;

  typedef struct packed {
    logic [1:0] pos;
  } bsic_cnt_t;
endpackage : bsic_pkg

// ==== hdl/bsic_burst_counter.sv ====
// two-bit burst position counter, loaded on capture and advanced on request
`timescale 1ns/100ps
`include "bsic_consts.svh"
module bsic_burst_counter
  import bsic_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_load,
  input  wire logic [1:0] i_start,
  input  wire logic       i_advance,
  output logic      [1:0] o_pos
);
  bsic_cnt_t cnt_reg;
  bsic_cnt_t cnt_next;

  // load wins over advance; wraps modulo four like the burst does
  always_comb begin
    cnt_next = cnt_reg;
    if (i_load) begin
      cnt_next.pos = i_start;             // see R2
    end else if (i_advance) begin
      cnt_next.pos = 2'(cnt_reg.pos + 2'h1);  // see R4
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg.pos <= `BSIC_POS_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign o_pos = cnt_reg.pos;
endmodule : bsic_burst_counter

// ==== sim/bsic_host_model.sv ====
// bus master model driving the synchronous inputs of the capture block
`timescale 1ns/100ps
`include "bsic_consts.svh"
module bsic_host_model (
  input  wire logic                    i_clock,
  output logic      [`BSIC_ADDR_W-1:0] o_addr,
  output logic      [12:0]             o_ctl
);
  // ctl: strobe p, strobe c, advance, ce1, ce2, ce3, bwe, lanes[3:0], gw, oe
  // idle: all three enables and output enable active, everything else released
  initial begin
    o_addr = '0;
    o_ctl  = 13'h1d7e;
  end
  // drive just after an edge and hold a whole cycle; address wiggles off capture edges
  task automatic put(input logic [12:0] c, input logic [`BSIC_ADDR_W-1:0] a);
    if (c[12] & c[11]) o_addr = ~o_addr;
    else o_addr = a;
    o_ctl = c;
    @(posedge i_clock);
    #1;
  endtask : put
endmodule : bsic_host_model

// ==== sim/tb_bsic_capture.sv ====
// self-checking bench for the burst sram input capture block
`timescale 1ns/100ps
`include "bsic_consts.svh"
module tb_bsic_capture;
  localparam logic [12:0] IDLE = 13'h1d7e, P = 13'h1000, C = 13'h0800, BURST_ADVANCE = 13'h0400;
  localparam logic [12:0] CE1 = 13'h0200, CE2 = 13'h0100, CE3 = 13'h0080, BYTE_WRITE_ENABLE = 13'h0040;
  localparam logic [12:0] L0 = 13'h0004, GW = 13'h0002, OE = 13'h0001;
  logic                    i_clock = 1'b0;
  logic                    i_rst   = 1'b1;
  logic [`BSIC_ADDR_W-1:0] m_addr, o_addr;
  logic [12:0]             m_ctl;
  logic [1:0]              o_burst_start_bits;
  logic                    o_access_active, o_write, o_deselect, o_data_oe;
  logic [`BSIC_LANES-1:0]  o_write_lanes;
  int                      err_count = 0, comparisons = 0, cycles = 0;
  always #12.5 i_clock = ~i_clock;
  bsic_host_model u_bsic_host_model (.i_clock(i_clock), .o_addr(m_addr), .o_ctl(m_ctl));
  bsic_capture u_bsic_capture (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(m_addr),
    .i_processor_addr_strobe_n(m_ctl[12]), .i_controller_addr_strobe_n(m_ctl[11]),
    .i_burst_advance_n(m_ctl[10]), .i_chip_enable_primary_n(m_ctl[9]),
    .i_chip_enable_high_side(m_ctl[8]), .i_chip_enable_third_n(m_ctl[7]),
    .i_byte_write_enable_n(m_ctl[6]), .i_byte_lane_select_n(m_ctl[5:2]),
    .i_global_write_n(m_ctl[1]), .i_output_enable_n(m_ctl[0]),
    .o_addr(o_addr), .o_burst_start_bits(o_burst_start_bits),
    .o_access_active(o_access_active), .o_write(o_write), .o_write_lanes(o_write_lanes),
    .o_deselect(o_deselect), .o_data_oe(o_data_oe));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // compare every output except o_data_oe at the current time, with no wait
  task automatic see(input logic [18:0] a, input logic [1:0] b, input logic act,
                     input logic wr, input logic [3:0] ln, input logic des);
    chk(o_addr, a);
    chk(o_burst_start_bits, b);
    chk(o_access_active, act);
    chk(o_write, wr);
    chk(o_write_lanes, ln);
    chk(o_deselect, des);
  endtask : see
  task automatic put(input logic [12:0] c, input logic [18:0] a);
    u_bsic_host_model.put(c, a);
  endtask : put
  // processor start, burst steps with wrap, enables ignored mid-burst, masked first read
  task automatic t_read;
    put(IDLE ^ P, 19'h12345);
    see(19'h12345, 2'h1, 1'b1, 1'b0, 4'h0, 1'b0);
    chk(o_data_oe, 1'b0);
    put(IDLE ^ BURST_ADVANCE, 19'h0);
    see(19'h12345, 2'h2, 1'b1, 1'b0, 4'h0, 1'b0);
    chk(o_data_oe, 1'b1);
    put(IDLE ^ BURST_ADVANCE ^ CE2, 19'h0);
    see(19'h12345, 2'h3, 1'b1, 1'b0, 4'h0, 1'b0);
    put(IDLE ^ BURST_ADVANCE ^ CE1 ^ CE3, 19'h0);
    see(19'h12345, 2'h0, 1'b1, 1'b0, 4'h0, 1'b0);
    put(IDLE, 19'h0);
    see(19'h12345, 2'h0, 1'b1, 1'b0, 4'h0, 1'b0);
    $display("test t_read done");
  endtask : t_read
  // byte lane write then global write inside the burst
  task automatic t_write;
    put(IDLE ^ BURST_ADVANCE ^ BYTE_WRITE_ENABLE ^ L0, 19'h0);
    see(19'h12345, 2'h1, 1'b1, 1'b1, 4'h1, 1'b0);
    put(IDLE ^ BURST_ADVANCE ^ L0, 19'h0);
    see(19'h12345, 2'h2, 1'b1, 1'b0, 4'h0, 1'b0);
    put(IDLE ^ BURST_ADVANCE ^ GW, 19'h0);
    see(19'h12345, 2'h3, 1'b1, 1'b1, 4'hf, 1'b0);
    $display("test t_write done");
  endtask : t_write
  // strobes with one enable inactive leave the block deselected and capture nothing
  task automatic t_desel;
    put(IDLE ^ C ^ CE2, 19'h00002);
    see(19'h12345, 2'h3, 1'b0, 1'b0, 4'h0, 1'b1);
    put(IDLE ^ C ^ CE3, 19'h00002);
    see(19'h12345, 2'h3, 1'b0, 1'b0, 4'h0, 1'b1);
    put(IDLE ^ C ^ CE1, 19'h00002);
    see(19'h12345, 2'h3, 1'b0, 1'b0, 4'h0, 1'b1);
    put(IDLE ^ P ^ CE1, 19'h00002);
    see(19'h12345, 2'h3, 1'b0, 1'b0, 4'h0, 1'b1);
    $display("test t_desel done");
  endtask : t_desel
  // both strobes act as processor start (read); controller start alone honours lanes
  task automatic t_both;
    put(IDLE ^ P ^ C ^ BYTE_WRITE_ENABLE ^ L0, 19'h00abe);
    see(19'h00abe, 2'h2, 1'b1, 1'b0, 4'h0, 1'b0);
    put(IDLE ^ C ^ BYTE_WRITE_ENABLE ^ L0, 19'h7fff3);
    see(19'h7fff3, 2'h3, 1'b1, 1'b1, 4'h1, 1'b0);
    $display("test t_both done");
  endtask : t_both
  // output enable released mid-burst, then a reset mid-run and a fresh start right after it
  task automatic t_reset;
    put(IDLE ^ BURST_ADVANCE ^ OE, 19'h0);
    see(19'h7fff3, 2'h0, 1'b1, 1'b0, 4'h0, 1'b0);
    chk(o_data_oe, 1'b0);
    put(IDLE ^ BURST_ADVANCE, 19'h0);
    see(19'h7fff3, 2'h1, 1'b1, 1'b0, 4'h0, 1'b0);
    chk(o_data_oe, 1'b1);
    i_rst = 1'b1;
    #1;
    see(19'h0, 2'h0, 1'b0, 1'b0, 4'h0, 1'b1);
    chk(o_data_oe, 1'b0);
    @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    put(IDLE ^ C, 19'h00005);
    see(19'h00005, 2'h1, 1'b1, 1'b0, 4'h0, 1'b0);
    chk(o_data_oe, 1'b0);
    $display("test t_reset done");
  endtask : t_reset
  task automatic finish_test;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // hang guard, well above the few dozen cycles of the run
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    see(19'h0, 2'h0, 1'b0, 1'b0, 4'h0, 1'b1);
    chk(o_data_oe, 1'b0);
    t_read();
    t_write();
    t_desel();
    t_both();
    t_reset();
    finish_test();
  end
endmodule : tb_bsic_capture
